//--- hw/ddac_pkg.sv
`default_nettype none
package ddac_pkg;
   localparam logic [7:0] ADDR_C0_LOW = 8'hf9;
   localparam logic [7:0] ADDR_C0_HIGH = 8'hfa;
   localparam logic [7:0] ADDR_C1_LOW = 8'hfb;
   localparam logic [7:0] ADDR_C1_HIGH = 8'hfc;
   localparam logic [7:0] ADDR_CONTROL = 8'hfd;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h04;
   localparam int BIT_MODE8 = 7;
   localparam int BIT_SPAN1 = 6;
   localparam int BIT_SPAN0 = 5;
   localparam int BIT_CLRN1 = 4;
   localparam int BIT_CLRN0 = 3;
   localparam int BIT_SYNC = 2;
   localparam int BIT_PWR1 = 1;
   localparam int BIT_PWR0 = 0;
   localparam int CFG_BIT_BYPASS = 5;
endpackage
`default_nettype wire

//--- hw/ddac_wr_if.sv
`timescale 1ns/1ps
`default_nettype none
// Write strobes toward one converter channel
interface ddac_wr_if;
   logic low_we;
   logic high_we;
   logic [7:0] wdata;
   logic load_all;
   logic mode8;
   logic [11:0] code;
   modport ctl (output low_we, high_we, wdata, load_all, mode8,
      input code);
   modport chan (input low_we, high_we, wdata, load_all, mode8,
      output code);
endinterface
`default_nettype wire

//--- hw/ddac_chan.sv
`timescale 1ns/1ps
`default_nettype none
module ddac_chan
   import ddac_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Control side
   ddac_wr_if.chan bus,
   input wire logic i_sync,
   // Register readback
   output logic [7:0] o_low,
   output logic [7:0] o_high
);
   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic [11:0] code;
   } ddac_chan_s;
   ddac_chan_s st_ff, nxt_st;

   // Hold bytes; the live code moves only on low write or sync rise
   always_comb begin
      nxt_st = st_ff;
      if (bus.high_we) begin
         nxt_st.high = bus.wdata;
      end
      if (bus.low_we) begin
         nxt_st.low = bus.wdata;
      end
      if ((bus.low_we && i_sync) || bus.load_all) begin
         if (bus.mode8) begin
            nxt_st.code = {4'h0, nxt_st.low};
         end else begin
            nxt_st.code = {nxt_st.high[3:0], nxt_st.low};
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_ff <= '{low: DATA_RESET, high: DATA_RESET, code: 12'h000};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bus.code = st_ff.code;
   assign o_low = st_ff.low;
   assign o_high = st_ff.high;

   a_low_update: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      bus.low_we && i_sync && !bus.mode8 |=>
      st_ff.code[7:0] == $past(bus.wdata))
      else $error("code not loaded on low write");
   a_hold_nosync: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !i_sync && !bus.load_all |=> $stable(st_ff.code))
      else $error("code moved while held");
   a_mode8_high: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      bus.mode8 && (bus.low_we || bus.load_all) |=>
      st_ff.code[11:8] == 4'h0)
      else $error("high byte leaked in 8-bit mode");
endmodule
`default_nettype wire

//--- hw/ddac_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ddac_ctrl
   import ddac_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Special function register port
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   // Configuration register buffer bit
   input wire logic [7:0] i_cfg,
   // Converter core controls
   output logic [11:0] o_code0,
   output logic [11:0] o_code1,
   output logic o_en0,
   output logic o_en1,
   output logic o_span_vdd0,
   output logic o_span_vdd1,
   output logic o_zero0,
   output logic o_zero1,
   output logic o_bypass0,
   output logic o_bypass1
);
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] rdata;
      logic [1:0] en;
      logic [1:0] span;
      logic [1:0] zero;
      logic [1:0] bypass;
   } ddac_ctrl_s;
   ddac_ctrl_s st_ff, nxt_st;

   ddac_wr_if w0 ();
   ddac_wr_if w1 ();
   logic [7:0] low0, high0, low1, high1;
   logic ctl_we, sync_rise;

   // Decode strobes
   assign ctl_we = i_wr && (i_addr == ADDR_CONTROL);
   assign sync_rise = ctl_we && i_wdata[BIT_SYNC] && !st_ff.ctl[BIT_SYNC];
   assign w0.low_we = i_wr && (i_addr == ADDR_C0_LOW);
   assign w0.high_we = i_wr && (i_addr == ADDR_C0_HIGH);
   assign w1.low_we = i_wr && (i_addr == ADDR_C1_LOW);
   assign w1.high_we = i_wr && (i_addr == ADDR_C1_HIGH);
   assign w0.wdata = i_wdata;
   assign w1.wdata = i_wdata;
   assign w0.load_all = sync_rise;
   assign w1.load_all = sync_rise;
   assign w0.mode8 = st_ff.ctl[BIT_MODE8];
   assign w1.mode8 = st_ff.ctl[BIT_MODE8];

   ddac_chan u_ch0 (.i_clk(i_clk), .i_nrst(i_nrst), .bus(w0),
      .i_sync(st_ff.ctl[BIT_SYNC]), .o_low(low0), .o_high(high0));
   ddac_chan u_ch1 (.i_clk(i_clk), .i_nrst(i_nrst), .bus(w1),
      .i_sync(st_ff.ctl[BIT_SYNC]), .o_low(low1), .o_high(high1));

   // Next state: control store, readback, registered core drives
   always_comb begin
      nxt_st = st_ff;
      if (ctl_we) begin
         nxt_st.ctl = i_wdata;
      end
      case (i_addr)
         ADDR_C0_LOW: nxt_st.rdata = low0;
         ADDR_C0_HIGH: nxt_st.rdata = high0;
         ADDR_C1_LOW: nxt_st.rdata = low1;
         ADDR_C1_HIGH: nxt_st.rdata = high1;
         ADDR_CONTROL: nxt_st.rdata = st_ff.ctl;
         default: nxt_st.rdata = 8'h00;
      endcase
      nxt_st.en = {st_ff.ctl[BIT_PWR1], st_ff.ctl[BIT_PWR0]};
      nxt_st.span = {st_ff.ctl[BIT_SPAN1], st_ff.ctl[BIT_SPAN0]};
      // Clear is active low in the register, active high to the core
      nxt_st.zero = {!st_ff.ctl[BIT_CLRN1], !st_ff.ctl[BIT_CLRN0]};
      // Bypass only honoured on reference span; supply span keeps buffer
      nxt_st.bypass[0] = i_cfg[CFG_BIT_BYPASS] && !st_ff.ctl[BIT_SPAN0];
      nxt_st.bypass[1] = i_cfg[CFG_BIT_BYPASS] && !st_ff.ctl[BIT_SPAN1];
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_ff <= '{ctl: CONTROL_RESET, rdata: 8'h00, en: 2'b00,
            span: 2'b00, zero: 2'b11, bypass: 2'b00};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Codes come straight from channel flops
   assign o_code0 = w0.code;
   assign o_code1 = w1.code;
   assign o_rdata = st_ff.rdata;
   assign o_en0 = st_ff.en[0];
   assign o_en1 = st_ff.en[1];
   assign o_span_vdd0 = st_ff.span[0];
   assign o_span_vdd1 = st_ff.span[1];
   assign o_zero0 = st_ff.zero[0];
   assign o_zero1 = st_ff.zero[1];
   assign o_bypass0 = st_ff.bypass[0];
   assign o_bypass1 = st_ff.bypass[1];

   // Control bits reach the core drives two edges after the write
   a_power_follow: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      ctl_we |=> ##1 o_en0 == $past(i_wdata[BIT_PWR0], 2))
      else $error("power enable wrong");
   a_power1_follow: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      ctl_we |=> ##1 o_en1 == $past(i_wdata[BIT_PWR1], 2))
      else $error("power enable 1 wrong");
   a_clear_follow: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      ctl_we |=> ##1 o_zero1 == !$past(i_wdata[BIT_CLRN1], 2))
      else $error("clear wrong");
   a_clear0_follow: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      ctl_we |=> ##1 o_zero0 == !$past(i_wdata[BIT_CLRN0], 2))
      else $error("clear 0 wrong");
   a_span_follow: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      ctl_we |=> ##1 o_span_vdd1 == $past(i_wdata[BIT_SPAN1], 2))
      else $error("span wrong");
   a_span0_follow: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      ctl_we |=> ##1 o_span_vdd0 == $past(i_wdata[BIT_SPAN0], 2))
      else $error("span 0 wrong");

   // Drives track the stored word even without a fresh write
   a_power_off: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !st_ff.ctl[BIT_PWR0] |=> !o_en0)
      else $error("converter 0 powered while off");
   a_power1_on: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      st_ff.ctl[BIT_PWR1] |=> o_en1)
      else $error("converter 1 not powered");
   a_zero_held: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !st_ff.ctl[BIT_CLRN1] |=> o_zero1)
      else $error("clear 1 not forcing zero");
   a_zero_free: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      st_ff.ctl[BIT_CLRN0] |=> !o_zero0)
      else $error("clear 0 stuck");

   // Bypass follows the config bit but never on the supply span
   a_bypass_ref: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      o_bypass0 |-> !o_span_vdd0)
      else $error("bypass on supply span");
   a_bypass1_ref: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      o_bypass1 |-> !o_span_vdd1)
      else $error("bypass 1 on supply span");
   a_bypass_set: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      i_cfg[CFG_BIT_BYPASS] && !st_ff.ctl[BIT_SPAN0] |=> o_bypass0)
      else $error("bypass not applied");
   a_bypass_clear: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !i_cfg[CFG_BIT_BYPASS] |=> !o_bypass0 && !o_bypass1)
      else $error("buffer bypassed while enabled");

   // One stored word carries mode and sync for both channels
   a_ctl_store: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      ctl_we |=> st_ff.ctl == $past(i_wdata))
      else $error("control write lost");
   a_ctl_hold: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !ctl_we |=> $stable(st_ff.ctl))
      else $error("control moved without write");

   // Converter codes: immediate and synchronised loads
   a_sync_both: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      sync_rise && !w0.mode8 && !w0.low_we && !w0.high_we |=>
      o_code0 == {high0[3:0], low0})
      else $error("sync load missed");
   a_sync1_both: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      sync_rise && !w1.mode8 |=> o_code1 == {high1[3:0], low1})
      else $error("sync load 1 missed");
   a_sync_narrow: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      sync_rise && w1.mode8 |=> o_code1 == {4'h0, low1})
      else $error("narrow sync load wrong");
   a_imm_wide: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      w1.low_we && st_ff.ctl[BIT_SYNC] && !w1.mode8 |=>
      o_code1 == {high1[3:0], $past(i_wdata)})
      else $error("immediate wide load wrong");
   a_imm_narrow: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      w1.low_we && st_ff.ctl[BIT_SYNC] && w1.mode8 |=>
      o_code1 == {4'h0, $past(i_wdata)})
      else $error("immediate narrow load wrong");
   a_high_nolaunch: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      w0.high_we |=> $stable(o_code0))
      else $error("high byte write moved the code");

   // Readback is one cycle behind the address
   a_rdata_ctl: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      i_addr == ADDR_CONTROL |=> o_rdata == $past(st_ff.ctl))
      else $error("control readback wrong");
   a_rdata_unmap: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !(i_addr inside {[ADDR_C0_LOW:ADDR_CONTROL]}) |=> o_rdata == 8'h00)
      else $error("unmapped readback not zero");

   // Main scenarios worth seeing at least once
   c_sync_rise: cover property (@(posedge i_clk) sync_rise);
   c_low_imm: cover property (@(posedge i_clk)
      w1.low_we && st_ff.ctl[BIT_SYNC]);
   c_mode8: cover property (@(posedge i_clk) w0.mode8 && w0.low_we);
   c_sync_narrow: cover property (@(posedge i_clk)
      sync_rise && w0.mode8);
   c_bypass_on: cover property (@(posedge i_clk) o_bypass0);
endmodule
`default_nettype wire

//--- testbench/ddac_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module ddac_ctrl_test
   import ddac_pkg::*;
   ();
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_wr = 1'b0;
   logic [7:0] i_addr = 8'hf9;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] i_cfg = 8'h00;
   logic [7:0] o_rdata;
   logic [11:0] o_code0, o_code1;
   logic o_en0, o_en1, o_span_vdd0, o_span_vdd1;
   logic o_zero0, o_zero1, o_bypass0, o_bypass1;
   int error_cnt = 0;
   int comparisons = 0;

   ddac_ctrl i_ddac_ctrl (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
      .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_cfg(i_cfg),
      .o_code0(o_code0), .o_code1(o_code1), .o_en0(o_en0), .o_en1(o_en1),
      .o_span_vdd0(o_span_vdd0), .o_span_vdd1(o_span_vdd1),
      .o_zero0(o_zero0), .o_zero1(o_zero1), .o_bypass0(o_bypass0),
      .o_bypass1(o_bypass1));

   // 40 MHz core clock
   always #12.5 i_clk = ~i_clk;

   // Four-state compare, so an unknown never matches
   task chk(input string name, input logic [11:0] seen,
      input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One-cycle write pulse, taken at the second edge
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // Control outputs lag two edges; three leaves margin
   task settle;
      repeat (3) @(posedge i_clk);
      #1;
   endtask

   // Read data is registered, one cycle behind the address
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_addr <= a;
      repeat (2) @(posedge i_clk);
      #1;
      chk("rdata", {4'h0, o_rdata}, {4'h0, exp});
   endtask

   // Core controls expected from a control value and config byte
   task look(input logic [7:0] v, input logic [7:0] c);
      chk("en", {10'h0, o_en1, o_en0}, {10'h0, v[1:0]});
      chk("span", {10'h0, o_span_vdd1, o_span_vdd0}, {10'h0, v[6:5]});
      chk("zero", {10'h0, o_zero1, o_zero0}, {10'h0, ~v[4:3]});
      chk("bypass", {10'h0, o_bypass1, o_bypass0},
         {10'h0, c[5] & ~v[6], c[5] & ~v[5]});
   endtask

   task ctl(input logic [7:0] v, input logic [7:0] c);
      @(posedge i_clk);
      i_cfg <= c;
      wr(ADDR_CONTROL, v);
      settle;
      look(v, c);
   endtask

   task t_reset;
      #1;
      look(CONTROL_RESET, 8'h00);
      chk("code0", o_code0, 12'h000);
      rd(ADDR_CONTROL, CONTROL_RESET);
      rd(ADDR_C1_HIGH, DATA_RESET);
      rd(8'hf8, 8'h00);
      $display("test reset done");
   endtask

   // High byte first, low byte launches the update
   task t_imm;
      // Reference span on both; converter reference assumed powered
      ctl(8'h1f, 8'h00);
      wr(ADDR_C0_HIGH, 8'h05);
      settle;
      chk("code0", o_code0, 12'h000);
      wr(ADDR_C0_LOW, 8'haa);
      wr(ADDR_C1_HIGH, 8'hf3);
      wr(ADDR_C1_LOW, 8'h21);
      settle;
      chk("code0", o_code0, 12'h5aa);
      chk("code1", o_code1, 12'h321);
      rd(ADDR_C1_HIGH, 8'hf3);
      $display("test immediate done");
   endtask

   // Writes held until sync rises, then both load together
   task t_sync;
      wr(ADDR_CONTROL, 8'h1b);
      wr(ADDR_C0_HIGH, 8'h0a);
      wr(ADDR_C0_LOW, 8'hbc);
      wr(ADDR_C1_HIGH, 8'h04);
      wr(ADDR_C1_LOW, 8'h56);
      settle;
      chk("code0", o_code0, 12'h5aa);
      chk("code1", o_code1, 12'h321);
      wr(ADDR_CONTROL, 8'h1f);
      settle;
      chk("code0", o_code0, 12'habc);
      chk("code1", o_code1, 12'h456);
      $display("test sync done");
   endtask

   // High bytes ignored in the narrow mode
   task t_mode8;
      ctl(8'h9f, 8'h00);
      wr(ADDR_C0_HIGH, 8'h0f);
      wr(ADDR_C0_LOW, 8'h12);
      wr(ADDR_C1_LOW, 8'h34);
      settle;
      chk("code0", o_code0, 12'h012);
      chk("code1", o_code1, 12'h034);
      // Held load in narrow mode still drops the high byte
      wr(ADDR_CONTROL, 8'h9b);
      wr(ADDR_C1_HIGH, 8'h07);
      wr(ADDR_C1_LOW, 8'h78);
      settle;
      chk("code1", o_code1, 12'h034);
      wr(ADDR_CONTROL, 8'h9f);
      settle;
      chk("code1", o_code1, 12'h078);
      $display("test mode8 done");
   endtask

   task t_ctrl;
      ctl(8'h5b, 8'h20);
      ctl(8'h64, 8'h20);
      chk("code0", o_code0, 12'hf12);
      chk("code1", o_code1, 12'h778);
      ctl(8'h7f, 8'h00);
      $display("test control done");
   endtask

   task close_out;
      $display("checks %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Guard against a hung run
   initial begin
      #200000;
      error_cnt++;
      close_out;
   end

   initial begin
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      t_reset;
      t_imm;
      t_sync;
      t_mode8;
      t_ctrl;
      close_out;
   end
endmodule
`default_nettype wire
